// file: hw/slc_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - protocol selector offers RTU, ASCII or three fieldbus options, RTU default.
// - choosing a fieldbus protocol pulses option board setup by itself.
// - modbus rates 1200 to 19.2K, default 9600.
// - fieldbus rates 38.4K to 500K only, default 125K.
// - new fieldbus rate stored but never applied, power cycle reloads 9600; Disabled applies at once.
// - rate Disabled switches the serial link off.
// - four character formats, default no parity 8 data 1 stop.
// - under fieldbus the character format is held at default.
// - station 1..247 default 1 modbus; 0..63 default 63 fieldbus.
// - fieldbus station change stored, previous one used until power cycle.
// - link watchdog runs only in Warning or Fault mode.
// - Fault mode with serial control: timeout raises code 42, coast stop, unless keypad code 40 is raised.
// - Warning mode timeout raises code 58 unless keypad code 40 is raised, motor keeps running.
// - keypad rate 9600 or 19200, default 19.2K.
// - keypad watchdog 2.0..60.0 s raises code 40 if reporting required.
// - command bit 0 serial command path, bit 1 serial reference.
// - bit 2 forward, bit 3 reverse, bit 4 second external reference.
// - bits 7..5 preset speed select, bit 5 lowest.
// - bits 8,9 ramps, 12 dc brake, 13 coast, 15 reset, 14 unused.
// - bit 10 remote, bit 11 terminal path, ignored under sequencer.
// - reading the command word returns last value written.
`include "slc_defines.svh"
module slc_bank #(
  parameter int CLK_HZ = `SLC_CLK_HZ, // core clock rate
  parameter int TENTH_CYC = CLK_HZ / `SLC_TENTH_HZ // cycles per 0.1 s
) (
  input wire logic core_clk_in, // core clock
  input wire logic nrst_in, // power-on reset, active low
  input wire logic wr_en_in, // parameter write strobe
  input wire logic rd_en_in, // parameter read strobe
  input wire logic [15:0] addr_in, // parameter address
  input wire logic [15:0] wdata_in, // write data
  input wire logic [1:0] link_wd_mode_in, // 0 off 1 warning 2 fault
  input wire logic kp_fault_req_in, // keypad control needs fault report
  input wire logic seq_app_in, // sequencer application selected
  input wire logic telegram_ok_in, // valid telegram pulse
  input wire logic keypad_ok_in, // keypad answered pulse
  output logic [15:0] rdata_out, // read data
  output logic rd_valid_out, // read data valid pulse
  output logic wr_ack_out, // write accepted pulse
  output logic wr_rej_out, // write refused pulse
  output logic [15:0] proto_out, // protocol in effect
  output logic [15:0] rate_out, // link rate in effect
  output logic [15:0] fmt_out, // character format in effect
  output logic [15:0] station_out, // station in effect
  output logic link_en_out, // serial link on
  output logic opt_setup_out, // option board setup pulse
  output logic [15:0] kp_rate_out, // keypad rate
  output logic [7:0] fault_code_out, // registered fault or warning code, 00 when no cause is active
  output logic coast_stop_out, // coast stop request
  output logic link_warn_out, // link warning active
  output logic serial_cmd_out, // serial command path
  output logic serial_ref_out, // serial reference source
  output logic fwd_out, // forward command
  output logic rev_out, // reverse command
  output logic second_external_speed_reference_out, // second ext ref select
  output logic [2:0] preset_out, // preset speed select
  output logic ramp1_out, // alternate ramp 1
  output logic ramp2_out, // alternate ramp 2
  output logic remote_out, // remote mode
  output logic term_path_out, // terminal strip path
  output logic dc_brake_out, // dc injection braking
  output logic coast_cmd_out, // freewheel stop command
  output logic inv_reset_out // inverter reset command
);
  slc_pkg::slc_word_t proto_reg, rate_reg, fmt_reg, station_reg;
  slc_pkg::slc_word_t lwd_reg, krate_reg, kwd_reg, cmd_reg;
  slc_pkg::slc_word_t rate_live_reg, station_live_reg, rate_next;
  slc_pkg::slc_word_t proto_prev_reg;
  slc_pkg::slc_wd_e lwd_state_reg;
  logic [31:0] lwd_cnt_reg, kwd_cnt_reg, lwd_lim, kwd_lim;
  logic [2:0] tel_sync_reg, kp_sync_reg;
  logic tel_seen, kp_seen, fb, boot_reg, kwd_armed_reg;
  logic accept;

  // fieldbus codes lie above ascii
  function automatic logic is_fb(input slc_pkg::slc_word_t p);
    is_fb = (p > `SLC_PROTO_ASCII);
  endfunction

  // range check of a write against the active protocol
  function automatic logic wr_legal(input logic [15:0] a,
                                    input slc_pkg::slc_word_t d,
                                    input logic f);
    unique case (a)
      `SLC_ADDR_PROTO: wr_legal = (d <= `SLC_PROTO_FB_MAX);
      `SLC_ADDR_RATE: wr_legal = (d == `SLC_RATE_OFF) ||
        (f ? (d >= `SLC_RATE_FB_MIN && d <= `SLC_RATE_FB_MAX)
           : (d <= `SLC_RATE_MB_MAX));
      `SLC_ADDR_FMT: wr_legal = !f && (d <= `SLC_FMT_MAX);
      `SLC_ADDR_STATION: wr_legal = f ? (d <= `SLC_STN_FB_MAX)
        : (d >= `SLC_STN_MB_MIN && d <= `SLC_STN_MB_MAX);
      `SLC_ADDR_LWDOG: wr_legal = (d >= `SLC_LWD_MIN && d <= `SLC_LWD_MAX);
      `SLC_ADDR_KRATE: wr_legal = (d <= `SLC_KRATE_19K2);
      `SLC_ADDR_KWDOG: wr_legal = (d >= `SLC_KWD_MIN && d <= `SLC_KWD_MAX);
      `SLC_ADDR_CMD: wr_legal = 1'b1;
      default: wr_legal = 1'b0;
    endcase
  endfunction

  assign fb = is_fb(proto_reg);
  assign accept = wr_en_in && wr_legal(addr_in, wdata_in, fb);
  assign tel_seen = tel_sync_reg[1] & ~tel_sync_reg[2]; // rise past sync
  assign kp_seen = kp_sync_reg[1] & ~kp_sync_reg[2];
  // seconds and tenths to cycles, kept wide to avoid overflow
  assign lwd_lim = lwd_reg * (TENTH_CYC * `SLC_TENTH_HZ);
  assign kwd_lim = kwd_reg * TENTH_CYC;
  // protocol change picks the default rate of the new family
  assign rate_next = is_fb(wdata_in) ? `SLC_RATE_125K : `SLC_RATE_9600;

  // pulses from the link side pass three flops; stage 0 is read by stage 1
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tel_sync_reg <= 3'h0;
      kp_sync_reg <= 3'h0;
    end else begin
      tel_sync_reg <= {tel_sync_reg[1:0], telegram_ok_in};
      kp_sync_reg <= {kp_sync_reg[1:0], keypad_ok_in};
    end
  end

  // stored settings; a protocol write reloads family defaults
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proto_reg <= `SLC_PROTO_RTU;
      rate_reg <= `SLC_RATE_9600;
      fmt_reg <= `SLC_FMT_NONE_8_1;
      station_reg <= `SLC_STN_MB_MIN;
      lwd_reg <= `SLC_LWD_DEF;
      krate_reg <= `SLC_KRATE_19K2;
      kwd_reg <= `SLC_KWD_DEF;
      cmd_reg <= 16'h0000;
    end else if (accept) begin
      unique case (addr_in)
        `SLC_ADDR_PROTO: begin
          proto_reg <= wdata_in;
          rate_reg <= rate_next;
          fmt_reg <= `SLC_FMT_NONE_8_1;
          station_reg <= is_fb(wdata_in) ? `SLC_STN_FB_MAX
                                         : `SLC_STN_MB_MIN;
        end
        `SLC_ADDR_RATE: rate_reg <= wdata_in;
        `SLC_ADDR_FMT: fmt_reg <= wdata_in;
        `SLC_ADDR_STATION: station_reg <= wdata_in;
        `SLC_ADDR_LWDOG: lwd_reg <= wdata_in;
        `SLC_ADDR_KRATE: krate_reg <= wdata_in;
        `SLC_ADDR_KWDOG: kwd_reg <= wdata_in;
        `SLC_ADDR_CMD: cmd_reg <= wdata_in;
        default: cmd_reg <= cmd_reg;
      endcase
    end
  end

  // values in effect; under fieldbus latched after reset or a protocol
  // switch; rate_out and station_out take the new family's codes one cycle after proto_out
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_reg <= 1'b1;
      proto_prev_reg <= `SLC_PROTO_RTU;
      rate_live_reg <= `SLC_RATE_9600;
      station_live_reg <= `SLC_STN_MB_MIN;
    end else begin
      boot_reg <= 1'b0;
      proto_prev_reg <= proto_reg;
      if (boot_reg || !fb || proto_reg != proto_prev_reg) begin
        rate_live_reg <= rate_reg;
        station_live_reg <= station_reg;
      end else if (rate_reg == `SLC_RATE_OFF) begin
        rate_live_reg <= rate_reg;
      end
    end
  end

  // bus answers
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
      rd_valid_out <= 1'b0;
      wr_ack_out <= 1'b0;
      wr_rej_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      wr_ack_out <= accept;
      wr_rej_out <= wr_en_in && !accept;
      if (rd_en_in) begin
        unique case (addr_in)
          `SLC_ADDR_PROTO: rdata_out <= proto_reg;
          `SLC_ADDR_RATE: rdata_out <= rate_reg;
          `SLC_ADDR_FMT: rdata_out <= fmt_reg;
          `SLC_ADDR_STATION: rdata_out <= station_reg;
          `SLC_ADDR_LWDOG: rdata_out <= lwd_reg;
          `SLC_ADDR_KRATE: rdata_out <= krate_reg;
          `SLC_ADDR_KWDOG: rdata_out <= kwd_reg;
          `SLC_ADDR_CMD: rdata_out <= cmd_reg;
          default: rdata_out <= 16'h0000;
        endcase
      end
    end
  end

  // configuration outputs; setup pulse on each accepted write of a fieldbus protocol code
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proto_out <= `SLC_PROTO_RTU;
      rate_out <= `SLC_RATE_9600;
      fmt_out <= `SLC_FMT_NONE_8_1;
      station_out <= `SLC_STN_MB_MIN;
      link_en_out <= 1'b0;
      opt_setup_out <= 1'b0;
      kp_rate_out <= `SLC_KRATE_19K2;
    end else begin
      proto_out <= proto_reg;
      rate_out <= rate_live_reg;
      fmt_out <= fmt_reg;
      station_out <= station_live_reg;
      link_en_out <= (rate_live_reg != `SLC_RATE_OFF);
      opt_setup_out <= accept && addr_in == `SLC_ADDR_PROTO &&
                       is_fb(wdata_in);
      kp_rate_out <= krate_reg;
    end
  end

  // link watchdog; count restarts on each telegram so a late one still saves
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lwd_state_reg <= slc_pkg::SLC_WD_IDLE;
      lwd_cnt_reg <= 32'h0;
    end else begin
      unique case (lwd_state_reg)
        slc_pkg::SLC_WD_IDLE: begin
          lwd_cnt_reg <= 32'h0;
          if (link_wd_mode_in == `SLC_WD_WARN ||
              link_wd_mode_in == `SLC_WD_FAULT)
            lwd_state_reg <= slc_pkg::SLC_WD_RUN;
        end
        slc_pkg::SLC_WD_RUN: begin
          if (link_wd_mode_in != `SLC_WD_WARN &&
              link_wd_mode_in != `SLC_WD_FAULT)
            lwd_state_reg <= slc_pkg::SLC_WD_IDLE;
          else if (tel_seen)
            lwd_cnt_reg <= 32'h0;
          else if (lwd_cnt_reg + 32'h1 >= lwd_lim)
            lwd_state_reg <= slc_pkg::SLC_WD_EXPIRED;
          else
            lwd_cnt_reg <= lwd_cnt_reg + 32'h1;
        end
        slc_pkg::SLC_WD_EXPIRED: begin
          lwd_cnt_reg <= 32'h0;
          if (tel_seen || (link_wd_mode_in != `SLC_WD_WARN &&
              link_wd_mode_in != `SLC_WD_FAULT))
            lwd_state_reg <= slc_pkg::SLC_WD_IDLE;
        end
      endcase
    end
  end

  // keypad watchdog
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      kwd_cnt_reg <= 32'h0;
      kwd_armed_reg <= 1'b0;
    end else if (kp_seen || !kp_fault_req_in) begin
      kwd_cnt_reg <= 32'h0;
      kwd_armed_reg <= 1'b0;
    end else if (kwd_cnt_reg + 32'h1 >= kwd_lim) begin
      kwd_armed_reg <= 1'b1;
    end else begin
      kwd_cnt_reg <= kwd_cnt_reg + 32'h1;
    end
  end

  // faults: fault 42 needs serial control; warning 58 never stops motor
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_code_out <= 8'h00;
      coast_stop_out <= 1'b0;
      link_warn_out <= 1'b0;
    end else begin
      link_warn_out <= 1'b0;
      coast_stop_out <= 1'b0;
      fault_code_out <= 8'h00;
      if (kwd_armed_reg) begin
        fault_code_out <= `SLC_CODE_KEYPAD;
      end else if (lwd_state_reg == slc_pkg::SLC_WD_EXPIRED) begin
        if (link_wd_mode_in == `SLC_WD_FAULT &&
            (cmd_reg[`SLC_CW_CMD] || cmd_reg[`SLC_CW_REF])) begin
          fault_code_out <= `SLC_CODE_LINK_FLT;
          coast_stop_out <= 1'b1;
        end else if (link_wd_mode_in == `SLC_WD_WARN) begin
          fault_code_out <= `SLC_CODE_LINK_WRN;
          link_warn_out <= 1'b1;
        end
      end
    end
  end

  // command word decode; bit 14 left unused
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_cmd_out <= 1'b0;
      serial_ref_out <= 1'b0;
      fwd_out <= 1'b0;
      rev_out <= 1'b0;
      second_external_speed_reference_out <= 1'b0;
      preset_out <= 3'h0;
      ramp1_out <= 1'b0;
      ramp2_out <= 1'b0;
      remote_out <= 1'b0;
      term_path_out <= 1'b0;
      dc_brake_out <= 1'b0;
      coast_cmd_out <= 1'b0;
      inv_reset_out <= 1'b0;
    end else begin
      serial_cmd_out <= cmd_reg[`SLC_CW_CMD];
      serial_ref_out <= cmd_reg[`SLC_CW_REF];
      fwd_out <= cmd_reg[`SLC_CW_FWD];
      rev_out <= cmd_reg[`SLC_CW_REV];
      second_external_speed_reference_out <= cmd_reg[`SLC_CW_REF2];
      preset_out <= cmd_reg[`SLC_CW_PS_HI:`SLC_CW_PS_LO];
      ramp1_out <= cmd_reg[`SLC_CW_RAMP1];
      ramp2_out <= cmd_reg[`SLC_CW_RAMP2];
      remote_out <= cmd_reg[`SLC_CW_REMOTE] && !seq_app_in;
      term_path_out <= cmd_reg[`SLC_CW_TERM] && !seq_app_in;
      dc_brake_out <= cmd_reg[`SLC_CW_DCB];
      coast_cmd_out <= cmd_reg[`SLC_CW_COAST];
      inv_reset_out <= cmd_reg[`SLC_CW_RESET];
    end
  end

  // checks
  sequence s_cmd_write;
    wr_en_in && addr_in == `SLC_ADDR_CMD;
  endsequence
  chk_cmd_readback: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) s_cmd_write ##1 (rd_en_in && !wr_en_in &&
    addr_in == `SLC_ADDR_CMD) |=> rdata_out == $past(wdata_in, 2))
    else $error("command readback mismatch");
  chk_fmt_locked: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) fb |-> fmt_reg == `SLC_FMT_NONE_8_1)
    else $error("format changed under fieldbus");
  chk_fb_rate: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) (fb && !boot_reg && $stable(proto_reg) &&
    rate_reg != `SLC_RATE_OFF) |=> $stable(rate_live_reg))
    else $error("fieldbus rate took effect early");
  chk_link_off: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) rate_live_reg == `SLC_RATE_OFF |=> !link_en_out)
    else $error("link on while disabled");
  chk_setup_pulse: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) (accept && addr_in == `SLC_ADDR_PROTO &&
    wdata_in > `SLC_PROTO_ASCII) |=> opt_setup_out)
    else $error("option setup missing");
  chk_wd_idle: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) (link_wd_mode_in == 2'h0) [*2] |->
    lwd_state_reg == slc_pkg::SLC_WD_IDLE)
    else $error("watchdog active while off");
  chk_wd_restart: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) (lwd_state_reg == slc_pkg::SLC_WD_RUN &&
    tel_seen && link_wd_mode_in != 2'h0 && link_wd_mode_in != 2'h3)
    |=> lwd_cnt_reg == 32'h0)
    else $error("watchdog not restarted");
  chk_warn_run: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) link_warn_out |-> !coast_stop_out &&
    fault_code_out == `SLC_CODE_LINK_WRN)
    else $error("warning stopped motor");
  chk_fault_code: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) coast_stop_out |-> fault_code_out ==
    `SLC_CODE_LINK_FLT)
    else $error("coast without code 42");
  chk_seq_block: assert property (@(posedge core_clk_in)
    disable iff (!nrst_in) $past(seq_app_in) |-> !remote_out &&
    !term_path_out)
    else $error("remote bits under sequencer");
endmodule // slc_bank

// file: inc/slc_defines.svh
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH
// parameter addresses of the communication group
`define SLC_ADDR_PROTO 16'h0384
`define SLC_ADDR_RATE 16'h0385
`define SLC_ADDR_FMT 16'h0386
`define SLC_ADDR_STATION 16'h0387
`define SLC_ADDR_LWDOG 16'h0388
`define SLC_ADDR_KRATE 16'h038A
`define SLC_ADDR_KWDOG 16'h038B
`define SLC_ADDR_CMD 16'h038C
// protocol codes
`define SLC_PROTO_RTU 16'h0000
`define SLC_PROTO_ASCII 16'h0001
`define SLC_PROTO_FB_MAX 16'h0004
// bit rate codes
`define SLC_RATE_OFF 16'h0000
`define SLC_RATE_9600 16'h0004
`define SLC_RATE_MB_MAX 16'h0005
`define SLC_RATE_FB_MIN 16'h0006
`define SLC_RATE_125K 16'h0007
`define SLC_RATE_FB_MAX 16'h0009
// character format codes
`define SLC_FMT_NONE_8_1 16'h0000
`define SLC_FMT_MAX 16'h0003
// station number limits and defaults
`define SLC_STN_MB_MIN 16'h0001
`define SLC_STN_MB_MAX 16'h00F7
`define SLC_STN_FB_MAX 16'h003F
// watchdog modes and limits, timeouts in seconds or tenths
`define SLC_WD_FAULT 2'h2
`define SLC_WD_WARN 2'h1
`define SLC_LWD_MIN 16'h0001
`define SLC_LWD_MAX 16'h003C
`define SLC_LWD_DEF 16'h0005
`define SLC_KWD_MIN 16'h0014
`define SLC_KWD_MAX 16'h0258
`define SLC_KWD_DEF 16'h0014
// keypad rates
`define SLC_KRATE_9600 16'h0000
`define SLC_KRATE_19K2 16'h0001
// fault codes
`define SLC_CODE_LINK_FLT 8'h2A
`define SLC_CODE_LINK_WRN 8'h3A
`define SLC_CODE_KEYPAD 8'h28
// command word bit positions
`define SLC_CW_CMD 0
`define SLC_CW_REF 1
`define SLC_CW_FWD 2
`define SLC_CW_REV 3
`define SLC_CW_REF2 4
`define SLC_CW_PS_LO 5
`define SLC_CW_PS_HI 7
`define SLC_CW_RAMP1 8
`define SLC_CW_RAMP2 9
`define SLC_CW_REMOTE 10
`define SLC_CW_TERM 11
`define SLC_CW_DCB 12
`define SLC_CW_COAST 13
`define SLC_CW_RESET 15
// timing
`define SLC_CLK_HZ 50000000
`define SLC_TENTH_HZ 10
`endif

// file: inc/slc_pkg.sv
package slc_pkg;
  typedef logic [15:0] slc_word_t;
  typedef enum logic [1:0] {
    SLC_WD_IDLE,
    SLC_WD_RUN,
    SLC_WD_EXPIRED
  } slc_wd_e;
endpackage

// file: verif/serial_link_config_and_control_word_tb.sv
`timescale 1ns/1ps
`include "slc_defines.svh"
module serial_link_config_and_control_word_tb;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr_en_in = 1'b0, rd_en_in = 1'b0, kp_fault_req_in = 1'b0;
  logic seq_app_in = 1'b0, keypad_ok_in = 1'b0, send_en = 1'b0;
  logic [15:0] addr_in = 16'h0000, wdata_in = 16'h0000;
  logic [1:0] link_wd_mode_in = 2'h0;
  logic telegram_ok_in, rd_valid_out, wr_ack_out, wr_rej_out, link_en_out;
  logic [15:0] rdata_out, proto_out, rate_out, fmt_out, station_out;
  logic [15:0] kp_rate_out, rd_word;
  logic [7:0] fault_code_out;
  logic [2:0] preset_out;
  logic opt_setup_out, coast_stop_out, link_warn_out, serial_cmd_out;
  logic serial_ref_out, fwd_out, rev_out, ramp1_out, ramp2_out;
  logic second_external_speed_reference_out;
  logic remote_out, term_path_out, dc_brake_out, coast_cmd_out;
  logic inv_reset_out, seen_pulse;
  logic [15:0] cw_seen;
  int n_fail = 0;
  int n_compared = 0;
  int n;

  // 50 MHz core clock
  always #10 core_clk_in = ~core_clk_in;
  // command outputs packed back into word order, bit 14 unused
  assign cw_seen = {inv_reset_out, 1'b0, coast_cmd_out, dc_brake_out,
    term_path_out, remote_out, ramp2_out, ramp1_out, preset_out,
    second_external_speed_reference_out, rev_out, fwd_out, serial_ref_out,
    serial_cmd_out};

  // tenth-second prescale shortened: one second is 100 cycles
  slc_bank #(.TENTH_CYC(10)) dut (
    .core_clk_in, .nrst_in, .wr_en_in, .rd_en_in, .addr_in, .wdata_in,
    .link_wd_mode_in, .kp_fault_req_in, .seq_app_in, .telegram_ok_in,
    .keypad_ok_in, .rdata_out, .rd_valid_out, .wr_ack_out, .wr_rej_out,
    .proto_out, .rate_out, .fmt_out, .station_out, .link_en_out,
    .opt_setup_out, .kp_rate_out, .fault_code_out, .coast_stop_out,
    .link_warn_out, .serial_cmd_out, .serial_ref_out, .fwd_out, .rev_out,
    .second_external_speed_reference_out, .preset_out, .ramp1_out,
    .ramp2_out, .remote_out,
    .term_path_out, .dc_brake_out, .coast_cmd_out, .inv_reset_out);
  slc_host_model #(.GAP(40)) host (.clk_in(core_clk_in), .nrst_in,
    .send_in(send_en), .telegram_ok_out(telegram_ok_in));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge core_clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
  endtask

  // one write; answer stands in the cycle after the taking edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic ok);
    @(posedge core_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
    #1;
    check("write ack", {15'h0000, wr_ack_out}, {15'h0000, ok});
    check("write refuse", {15'h0000, wr_rej_out}, {15'h0000, !ok});
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge core_clk_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1;
    check("read valid", {15'h0000, rd_valid_out}, 16'h0001);
    rd_word = rdata_out;
  endtask

  task automatic wait_code(input logic [7:0] code);
    n = 0;
    while (fault_code_out !== code && n < 600) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check("fault code", {8'h00, fault_code_out}, {8'h00, code});
  endtask

  task automatic t_defaults();
    check("protocol", proto_out, `SLC_PROTO_RTU);
    check("rate", rate_out, `SLC_RATE_9600);
    check("format", fmt_out, `SLC_FMT_NONE_8_1);
    check("station", station_out, `SLC_STN_MB_MIN);
    check("keypad rate", kp_rate_out, `SLC_KRATE_19K2);
    check("link on", {15'h0000, link_en_out}, 16'h0001);
    rd(`SLC_ADDR_KWDOG);
    check("keypad timeout", rd_word, `SLC_KWD_DEF);
    rd(`SLC_ADDR_CMD);
    check("command word", rd_word, 16'h0000);
    rd(16'h0389);
    check("unmapped read", rd_word, 16'h0000);
    wr(16'h0389, 16'h0001, 1'b0);
    $display("test defaults done");
  endtask

  task automatic t_modbus();
    wr(`SLC_ADDR_STATION, 16'h0000, 1'b0);
    wr(`SLC_ADDR_STATION, `SLC_STN_MB_MAX, 1'b1);
    wr(`SLC_ADDR_STATION, 16'h00F8, 1'b0);
    rd(`SLC_ADDR_STATION);
    check("station", station_out, `SLC_STN_MB_MAX);
    for (int f = 0; f <= 4; f++) begin
      wr(`SLC_ADDR_FMT, 16'(f), f <= 3);
      rd(`SLC_ADDR_FMT);
      check("format", fmt_out, (f <= 3) ? 16'(f) : 16'h0003);
    end
    for (int r = 1; r <= 6; r++) begin
      wr(`SLC_ADDR_RATE, 16'(r), r <= 5);
      rd(`SLC_ADDR_RATE);
      check("rate", rd_word, (r <= 5) ? 16'(r) : 16'h0005);
    end
    wr(`SLC_ADDR_RATE, `SLC_RATE_OFF, 1'b1);
    rd(`SLC_ADDR_RATE);
    check("link off", {15'h0000, link_en_out}, 16'h0000);
    wr(`SLC_ADDR_PROTO, `SLC_PROTO_ASCII, 1'b1);
    wr(`SLC_ADDR_PROTO, 16'h0005, 1'b0);
    rd(`SLC_ADDR_PROTO);
    check("protocol", rd_word, `SLC_PROTO_ASCII);
    $display("test modbus settings done");
  endtask

  task automatic t_command();
    logic [15:0] pats [5] = '{16'h0013, 16'h5555, 16'hAAAA, 16'h00A0,
                              16'hFFFF};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in);
      seq_app_in <= (i >= 5);
      wr(`SLC_ADDR_CMD, pats[i % 5], 1'b1);
      rd(`SLC_ADDR_CMD);
      check("command read", rd_word, pats[i % 5]);
      check("command outs", cw_seen, pats[i % 5] &
            ((i >= 5) ? 16'hB3FF : 16'hBFFF));
    end
    // write then read on the very next edge: the read sees the new word
    @(posedge core_clk_in);
    wr_en_in <= 1'b1;
    addr_in <= `SLC_ADDR_CMD;
    wdata_in <= 16'h1234;
    @(posedge core_clk_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b1;
    @(posedge core_clk_in);
    rd_en_in <= 1'b0;
    #1;
    check("back to back", rdata_out, 16'h1234);
    seq_app_in <= 1'b0;
    $display("test command word done");
  endtask

  task automatic t_fieldbus();
    seen_pulse = 1'b0;
    fork
      wr(`SLC_ADDR_PROTO, 16'h0002, 1'b1);
      repeat (4) begin
        @(posedge core_clk_in);
        #2;
        seen_pulse |= opt_setup_out;
      end
    join
    check("option setup", {15'h0000, seen_pulse}, 16'h0001);
    rd(`SLC_ADDR_RATE);
    check("bus rate", rd_word, `SLC_RATE_125K);
    rd(`SLC_ADDR_STATION);
    check("bus station", rd_word, `SLC_STN_FB_MAX);
    wr(`SLC_ADDR_RATE, `SLC_RATE_9600, 1'b0);
    wr(`SLC_ADDR_RATE, `SLC_RATE_FB_MAX, 1'b1);
    rd(`SLC_ADDR_RATE);
    check("rate stored", rd_word, `SLC_RATE_FB_MAX);
    check("rate held", rate_out, `SLC_RATE_125K);
    wr(`SLC_ADDR_FMT, 16'h0001, 1'b0);
    check("format held", fmt_out, `SLC_FMT_NONE_8_1);
    wr(`SLC_ADDR_STATION, 16'h0040, 1'b0);
    wr(`SLC_ADDR_STATION, 16'h0000, 1'b1);
    rd(`SLC_ADDR_STATION);
    check("station stored", rd_word, 16'h0000);
    check("station held", station_out, `SLC_STN_FB_MAX);
    do_reset();
    $display("test fieldbus settings done");
  endtask

  task automatic t_link_watchdog();
    wr(`SLC_ADDR_LWDOG, `SLC_LWD_MIN, 1'b1);
    wr(`SLC_ADDR_LWDOG, 16'h003D, 1'b0);
    wr(`SLC_ADDR_CMD, 16'h0001, 1'b1);
    repeat (300) @(posedge core_clk_in);
    check("watchdog off", {8'h00, fault_code_out}, 16'h0000);
    link_wd_mode_in <= `SLC_WD_FAULT;
    send_en <= 1'b1;
    repeat (400) @(posedge core_clk_in);
    check("kept alive", {8'h00, fault_code_out}, 16'h0000);
    send_en <= 1'b0;
    wait_code(`SLC_CODE_LINK_FLT);
    check("not early", {15'h0000, n >= 50}, 16'h0001);
    check("coast", {15'h0000, coast_stop_out}, 16'h0001);
    link_wd_mode_in <= 2'h3;
    wait_code(8'h00);
    @(posedge core_clk_in);
    link_wd_mode_in <= `SLC_WD_WARN;
    wait_code(`SLC_CODE_LINK_WRN);
    check("warn", {15'h0000, link_warn_out}, 16'h0001);
    check("runs on", {15'h0000, coast_stop_out}, 16'h0000);
    link_wd_mode_in <= 2'h0;
    do_reset();
    $display("test link watchdog done");
  endtask

  task automatic t_keypad();
    wr(`SLC_ADDR_KRATE, `SLC_KRATE_9600, 1'b1);
    wr(`SLC_ADDR_KRATE, 16'h0002, 1'b0);
    check("keypad rate", kp_rate_out, `SLC_KRATE_9600);
    wr(`SLC_ADDR_KWDOG, 16'h0013, 1'b0);
    wr(`SLC_ADDR_KWDOG, `SLC_KWD_MAX, 1'b1);
    wr(`SLC_ADDR_KWDOG, `SLC_KWD_MIN, 1'b1);
    kp_fault_req_in <= 1'b1;
    repeat (8) begin
      repeat (60) @(posedge core_clk_in);
      keypad_ok_in <= 1'b1;
      @(posedge core_clk_in);
      keypad_ok_in <= 1'b0;
    end
    check("keypad alive", {8'h00, fault_code_out}, 16'h0000);
    wait_code(`SLC_CODE_KEYPAD);
    check("not early", {15'h0000, n >= 150}, 16'h0001);
    kp_fault_req_in <= 1'b0;
    wait_code(8'h00);
    do_reset();
    $display("test keypad done");
  endtask

  // hang guard: well beyond the length of the sequence below
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial begin
    do_reset();
    t_defaults();
    t_modbus();
    t_command();
    t_fieldbus();
    t_link_watchdog();
    t_keypad();
    report_and_stop();
  end
endmodule // serial_link_config_and_control_word_tb

// file: verif/slc_host_model.sv
`timescale 1ns/1ps
// far-side host: keeps the link alive with short valid-telegram pulses
module slc_host_model #(
  parameter int GAP = 40 // cycles between telegrams
) (
  input wire logic clk_in, // core clock
  input wire logic nrst_in, // reset, active low
  input wire logic send_in, // keep sending telegrams
  output logic telegram_ok_out // valid telegram pulse
);
  int cnt;
  // one pulse per GAP cycles, gap chosen well inside the timeout
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 0;
      telegram_ok_out <= 1'b0;
    end else begin
      cnt <= (send_in && cnt < GAP - 1) ? cnt + 1 : 0;
      telegram_ok_out <= send_in && (cnt == GAP - 1);
    end
  end
endmodule // slc_host_model
